// >>> hdl/wdt_bounds.sv
`timescale 1ns/1ps
// =====================================================================
// least and greatest timeout, in oscillator periods
module wdt_bounds
   import wdt_pkg::*;
(
   input  wire logic mclk_i,
   input  wire logic rst_i,
   wdt_bnd_if.calc   bnd
);
   logic [23:0] msb;
   logic [23:0] lsb;
   logic [23:0] cnt;
   logic [23:0] quo;
   logic [23:0] stp;

   // timebase constants, quotient truncates toward zero
   always_comb begin
      unique case (bnd.tb)
         2'h0: begin msb = 24'h000004; lsb = 24'h00003B; end
         2'h1: begin msb = 24'h000008; lsb = 24'h000035; end
         2'h2: begin msb = 24'h000014; lsb = 24'h000023; end
         2'h3: begin msb = 24'h000031; lsb = 24'h000036; end
      endcase
      cnt = 24'(bnd.cnt);
      quo = (cnt << 2) / msb;
      stp = 24'(BND_STEP * (cnt - quo) + (BND_CORADD + lsb) * BND_SCALE * quo);
   end

   // registered bounds
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         bnd.tmin <= '0;
         bnd.tmax <= '0;
      end else begin
         bnd.tmin <= 24'((lsb + BND_MINADD) * BND_SCALE)
                   + ((cnt < (msb >> 2)) ? 24'(BND_STEP * cnt) : stp);
         bnd.tmax <= BND_STEP
                   + ((cnt <= (msb >> 2)) ? 24'(BND_STEP * cnt) : stp);
      end
   end

   chk_max_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
      (bnd.cnt == '0) |=> (bnd.tmax == BND_STEP))
      else $error("greatest timeout at zero count wrong");
   chk_min_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
      (bnd.cnt == '0 && bnd.tb == 2'h0) |=> (bnd.tmin == 24'h002EC0))
      else $error("least timeout at zero count wrong");
endmodule

// >>> hdl/wdt_core.sv
`timescale 1ns/1ps
// =====================================================================
// watchdog: counter, activation, halt handling, register port

// How it works
// - counter decrements every 16384 oscillator periods in run state, enabled or not
// - active and top bit clears: system reset
// - activation bit set by software, cleared by reset
// - control reads 7Fh after reset
// - count value is low six counter bits
// - bounds constants chosen by timebase select
// - greatest timeout formula with quarter-step correction
// - least timeout formula with same correction
// - bound divisions truncate toward zero
// - plain halt: one decrement, then frozen, no reset
// - external wake from plain halt: 256/4096 delay
// - reset ends plain halt: watchdog disabled again
// - halt with halt-reset option, timer interrupt off: reset instead
// - halt with timer interrupt: active-halt, counter stops
// - active-halt interrupt exit: resume at once
// - active-halt reset exit: resume after delay
// - hardware option: always active, bit ignored
module wdt_core
   import wdt_pkg::*;
#(
   parameter int PRESCALE = PRESCALE_DIV
) (
   input  wire logic              mclk_i,
   input  wire logic              rst_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [DATA_W-1:0] rdata_o,
   input  wire logic              halt_exec_i,
   input  wire logic              ext_irq_i,
   input  wire logic              osc_irq_i,
   input  wire logic              sys_reset_i,
   output logic                   wdg_reset_o,
   output logic                   halted_o,
   output logic                   act_halted_o
);

   if (PRESCALE < 2) begin : g_bad
      $error("prescale must be at least 2");
   end

   // =====================================================================
   // declarations
   wdt_state_t       state;
   logic [CNT_W-1:0] cnt;
   logic             act_bit;
   logic [7:0]       opt;
   logic [7:0]       clkcfg;
   logic             dec_pending;
   logic [12:0]      wake_cnt;
   logic [12:0]      wake_len;
   logic             tick;
   logic             soft_rst;
   logic             wdg_active;
   logic             counting;
   logic             reset_req;
   logic [7:0]       bnd_idx;
   logic [47:0]      bnd_bytes;

   wdt_bnd_if bnd ();

   // address match, used for writes and reads
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] reg_addr);
      hit = (a == reg_addr);
   endfunction

   // =====================================================================
   // sub-blocks
   wdt_prescaler #(
      .DIV    (PRESCALE)
   ) u_pre (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .tick_o (tick)
   );

   wdt_bounds u_bnd (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .bnd    (bnd.calc)
   );

   assign bnd.cnt = cnt[CVAL_W-1:0];
   assign bnd.tb  = clkcfg[CLK_TB_LO +: 2];

   // =====================================================================
   // control terms
   // system reset and our own reset both return the watchdog to reset state
   assign soft_rst   = sys_reset_i | wdg_reset_o;
   assign wdg_active = act_bit | opt[OPT_HW];
   // run state covers slow and wait, which do not affect the counter
   assign counting   = (state == ST_RUN) | ((state == ST_HALT) & dec_pending);
   assign wake_len   = opt[OPT_LWAKE] ? WAKE_LONG : WAKE_SHORT;
   assign reset_req  = (wdg_active & ~cnt[TOP_BIT] & (state != ST_HALT))
                     | (halt_exec_i & (state == ST_RUN)
                        & ~clkcfg[CLK_TIE] & opt[OPT_HRST]);

   // =====================================================================
   // reset request pulse, one cycle then counter reloads
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         wdg_reset_o <= 1'b0;
      end else begin
         wdg_reset_o <= reset_req & ~wdg_reset_o;
      end
   end

   // =====================================================================
   // activation bit, software can only set it
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         act_bit <= 1'b0;
      end else if (soft_rst) begin
         act_bit <= 1'b0;
      end else if (wr_i && hit(addr_i, ADDR_CTRL) && state == ST_RUN) begin
         act_bit <= act_bit | wdata_i[ACT_BIT];
      end
   end

   // =====================================================================
   // down-counter, free running while the cpu runs
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt <= CNT_RST;
      end else if (soft_rst) begin
         cnt <= CNT_RST;
      end else if (wr_i && hit(addr_i, ADDR_CTRL) && state == ST_RUN) begin
         cnt <= wdata_i[CNT_W-1:0];
      end else if (tick && counting) begin
         cnt <= cnt - 1'b1;
      end
   end

   // =====================================================================
   // option and clock-configuration copies
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         opt    <= OPT_RST;
         clkcfg <= CLK_RST;
      end else if (wr_i && state == ST_RUN) begin
         if (hit(addr_i, ADDR_OPT)) begin
            opt <= wdata_i;
         end
         if (hit(addr_i, ADDR_CLKCFG)) begin
            clkcfg <= wdata_i;
         end
      end
   end

   // =====================================================================
   // halt handling state machine
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= ST_RUN;
      end else begin
         unique case (state)
            ST_RUN: begin
               if (halt_exec_i && !soft_rst) begin
                  if (clkcfg[CLK_TIE]) begin
                     state <= ST_ACT_HALT;
                  end else if (!opt[OPT_HRST]) begin
                     state <= ST_HALT;
                  end
               end
            end
            ST_HALT: begin
               if (soft_rst) begin
                  state <= ST_RUN;
               end else if (ext_irq_i) begin
                  state <= ST_WAKE;
               end
            end
            ST_ACT_HALT: begin
               if (soft_rst) begin
                  state <= ST_WAKE;
               end else if (ext_irq_i || osc_irq_i) begin
                  state <= ST_RUN;
               end
            end
            ST_WAKE: begin
               if (wake_cnt == wake_len - 1'b1) begin
                  state <= ST_RUN;
               end
            end
         endcase
      end
   end

   // =====================================================================
   // single decrement owed on plain halt entry
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         dec_pending <= 1'b0;
      end else if (state == ST_RUN && halt_exec_i && !soft_rst
                   && !clkcfg[CLK_TIE] && !opt[OPT_HRST]) begin
         dec_pending <= 1'b1;
      end else if (state != ST_HALT || tick) begin
         dec_pending <= 1'b0;
      end
   end

   // =====================================================================
   // wake-up delay counter
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         wake_cnt <= '0;
      end else if (state == ST_WAKE) begin
         wake_cnt <= wake_cnt + 1'b1;
      end else begin
         wake_cnt <= '0;
      end
   end

   // =====================================================================
   // mode outputs
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         halted_o     <= 1'b0;
         act_halted_o <= 1'b0;
      end else begin
         halted_o     <= (state == ST_HALT);
         act_halted_o <= (state == ST_ACT_HALT);
      end
   end

   // =====================================================================
   // read port, data in the cycle after the strobe
   assign bnd_idx   = addr_i - ADDR_BND;
   assign bnd_bytes = {bnd.tmax, bnd.tmin};

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= READ_NONE;
      end else if (rd_i) begin
         if (hit(addr_i, ADDR_CTRL)) begin
            rdata_o <= {act_bit, cnt};
         end else if (hit(addr_i, ADDR_OPT)) begin
            rdata_o <= opt;
         end else if (hit(addr_i, ADDR_CLKCFG)) begin
            rdata_o <= clkcfg;
         end else if (hit(addr_i, ADDR_STAT)) begin
            rdata_o <= {3'h0, counting, state == ST_WAKE, state == ST_ACT_HALT,
                        state == ST_HALT, wdg_active};
         end else if (bnd_idx < BND_BYTES) begin
            rdata_o <= bnd_bytes[bnd_idx[2:0]*8 +: 8];
         end else begin
            rdata_o <= READ_NONE;                            // unmapped
         end
      end else begin
         rdata_o <= READ_NONE;
      end
   end

   // =====================================================================
   // checks
   chk_tick_decrement: assert property (@(posedge mclk_i) disable iff (rst_i)
      (tick && state == ST_RUN && !soft_rst && !wr_i) |=> (cnt == $past(cnt) - 1'b1))
      else $error("counter missed its prescaler tick");

   chk_top_reset: assert property (@(posedge mclk_i) disable iff (rst_i)
      (wdg_active && !cnt[TOP_BIT] && state == ST_RUN && !wdg_reset_o)
      |=> wdg_reset_o ##1 (cnt == CNT_RST))
      else $error("no reset after top bit cleared");

   chk_act_sticky: assert property (@(posedge mclk_i) disable iff (rst_i)
      (act_bit && !soft_rst) |=> act_bit)
      else $error("activation bit cleared without reset");

   chk_reset_value: assert property (@(posedge mclk_i) disable iff (rst_i)
      soft_rst |=> (cnt == CNT_RST && !act_bit))
      else $error("control register not at reset value");

   chk_halt_frozen: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state == ST_HALT && !dec_pending && !sys_reset_i) |=> ($stable(cnt) && !wdg_reset_o))
      else $error("counter moved in plain halt");

   chk_halt_wake: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state == ST_HALT && ext_irq_i && !soft_rst && !opt[OPT_LWAKE])
      |=> (state == ST_WAKE) [*8] ##[240:260] (state == ST_RUN))
      else $error("wake delay from halt wrong");

   chk_halt_sysrst: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state == ST_HALT && sys_reset_i) |=> (state == ST_RUN && !act_bit))
      else $error("reset did not end plain halt");

   chk_halt_option: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state == ST_RUN && halt_exec_i && !clkcfg[CLK_TIE] && opt[OPT_HRST] && !soft_rst)
      |=> (wdg_reset_o && state == ST_RUN))
      else $error("halt with option gave no reset");

   chk_act_enter: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state == ST_RUN && halt_exec_i && clkcfg[CLK_TIE] && !soft_rst)
      |=> (state == ST_ACT_HALT) ##1 ($stable(cnt) && !wdg_reset_o))
      else $error("active-halt entry wrong");

   chk_act_exit: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state == ST_ACT_HALT && (osc_irq_i || ext_irq_i) && !soft_rst)
      |=> (state == ST_RUN))
      else $error("active-halt exit delayed");

   chk_act_rst_exit: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state == ST_ACT_HALT && sys_reset_i) |=> (state == ST_WAKE))
      else $error("reset exit from active-halt skipped delay");

   chk_hw_active: assert property (@(posedge mclk_i) disable iff (rst_i)
      (opt[OPT_HW] && !act_bit && !cnt[TOP_BIT] && state == ST_RUN && !wdg_reset_o)
      |=> wdg_reset_o)
      else $error("hardware option gave no reset");
endmodule

// >>> hdl/wdt_prescaler.sv
`timescale 1ns/1ps
// =====================================================================
// free-running prescaler, one tick per DIV oscillator periods
module wdt_prescaler
   import wdt_pkg::*;
#(
   parameter int DIV = PRESCALE_DIV
) (
   input  wire logic mclk_i,
   input  wire logic rst_i,
   output logic      tick_o
);
   localparam int PW = $clog2(DIV);

   if (DIV < 2) begin : g_bad
      $error("prescaler divide must be at least 2");
   end

   logic [PW-1:0] phase;

   // phase counter, never stopped, drives only the watchdog counter
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         phase  <= '0;
         tick_o <= 1'b0;
      end else begin
         tick_o <= (phase == PW'(DIV - 2));
         phase  <= (phase == PW'(DIV - 1)) ? '0 : phase + 1'b1;
      end
   end
endmodule

// >>> shared/wdt_bnd_if.sv
`timescale 1ns/1ps
// =====================================================================
// count value and timebase in, timeout bounds out
interface wdt_bnd_if;
   import wdt_pkg::*;
   logic [CVAL_W-1:0] cnt;
   logic [1:0]        tb;
   logic [BND_W-1:0]  tmin;
   logic [BND_W-1:0]  tmax;
   modport calc (input cnt, input tb, output tmin, output tmax);
   modport user (output cnt, output tb, input tmin, input tmax);
endinterface

// >>> shared/wdt_pkg.sv
// =====================================================================
// watchdog constants and types
package wdt_pkg;

   // =====================================================================
   // register port and map
   localparam int         ADDR_W      = 8;
   localparam int         DATA_W      = 8;
   localparam logic [7:0] ADDR_CTRL   = 8'h2A;  // watchdog_control_reg
   localparam logic [7:0] ADDR_OPT    = 8'h2B;  // option bits
   localparam logic [7:0] ADDR_CLKCFG = 8'h2C;  // copy of clock_control_status_reg
   localparam logic [7:0] ADDR_STAT   = 8'h2D;  // watchdog state
   localparam logic [7:0] ADDR_BND    = 8'h30;  // six bytes: tmin then tmax, lsb first
   localparam logic [7:0] BND_BYTES   = 8'h06;
   localparam logic [7:0] READ_NONE   = 8'h00;

   // =====================================================================
   // fields and reset values
   localparam int         CNT_W       = 7;
   localparam int         CVAL_W      = 6;
   localparam int         ACT_BIT     = 7;
   localparam int         TOP_BIT     = 6;
   localparam logic [6:0] CNT_RST     = 7'h7F;
   localparam int         OPT_HRST    = 0;      // halt_reset_option
   localparam int         OPT_HW      = 1;      // hardware watchdog option
   localparam int         OPT_LWAKE   = 2;      // long wake-up delay
   localparam logic [7:0] OPT_RST     = 8'h00;
   localparam int         CLK_TIE     = 1;      // timer_interrupt_enable
   localparam int         CLK_TB_LO   = 2;      // timebase_select, two bits
   localparam logic [7:0] CLK_RST     = 8'h00;

   // =====================================================================
   // timing, in oscillator or cpu clocks
   localparam int          PRESCALE_DIV = 16384;
   localparam logic [12:0] WAKE_SHORT   = 13'h0100;  // 256 cpu clocks
   localparam logic [12:0] WAKE_LONG    = 13'h1000;  // 4096 cpu clocks

   // =====================================================================
   // timeout bound arithmetic
   localparam int          BND_W      = 24;
   localparam logic [23:0] BND_STEP   = 24'h004000;  // 16384 per count
   localparam logic [23:0] BND_SCALE  = 24'h000040;  // 64
   localparam logic [23:0] BND_MINADD = 24'h000080;  // 128
   localparam logic [23:0] BND_CORADD = 24'h0000C0;  // 192

   typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_ACT_HALT, ST_WAKE} wdt_state_t;

endpackage

// >>> test/wdt_core_tb.sv
`timescale 1ns/1ps
// =====================================================================
// register-level bench for the watchdog core
module wdt_core_tb;
   import wdt_pkg::*;

   localparam int P = 64;  // shortened prescale for simulation

   logic              mclk_i;
   logic              rst_i;
   logic [ADDR_W-1:0] addr_i;
   logic [DATA_W-1:0] wdata_i;
   logic              wr_i;
   logic              rd_i;
   logic [DATA_W-1:0] rdata_o;
   logic              halt_exec_i;
   logic              ext_irq_i;
   logic              osc_irq_i;
   logic              sys_reset_i;
   logic              wdg_reset_o;
   logic              halted_o;
   logic              act_halted_o;
   logic [7:0]        a;
   logic [7:0]        b;
   logic [7:0]        by [6];
   int                fails;
   int                cmp_count;
   int                t;
   int                k;
   int                c;
   int                i;
   int                cs [4];
   int                msb [4] = '{4, 8, 20, 49};
   int                lsb [4] = '{59, 53, 35, 54};

   wdt_core #(.PRESCALE(P)) u_dut (
      .mclk_i       (mclk_i),
      .rst_i        (rst_i),
      .addr_i       (addr_i),
      .wdata_i      (wdata_i),
      .wr_i         (wr_i),
      .rd_i         (rd_i),
      .rdata_o      (rdata_o),
      .halt_exec_i  (halt_exec_i),
      .ext_irq_i    (ext_irq_i),
      .osc_irq_i    (osc_irq_i),
      .sys_reset_i  (sys_reset_i),
      .wdg_reset_o  (wdg_reset_o),
      .halted_o     (halted_o),
      .act_halted_o (act_halted_o)
   );

   // =====================================================================
   // clock and hang guard
   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end

   // cut a hang short after a fixed number of cycles
   initial begin
      repeat (100000) @(posedge mclk_i);
      fails++;
      $display("[FAIL] run expected finish seen timeout");
      test_done();
   end

   // =====================================================================
   // helpers
   task automatic test_done;
      if (fails == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge mclk_i);
      addr_i  <= ad;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge mclk_i);
      wr_i    <= 1'b0;
   endtask

   // data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] ad, output logic [7:0] d);
      @(posedge mclk_i);
      addr_i <= ad;
      rd_i   <= 1'b1;
      @(posedge mclk_i);
      rd_i   <= 1'b0;
      #1;
      d = rdata_o;
   endtask

   // one-cycle pulse: 0 halt, 1 external, 2 timer, 3 system reset
   task automatic pulse(input int s);
      @(posedge mclk_i);
      case (s)
         0: halt_exec_i <= 1'b1;
         1: ext_irq_i <= 1'b1;
         2: osc_irq_i <= 1'b1;
         default: sys_reset_i <= 1'b1;
      endcase
      @(posedge mclk_i);
      halt_exec_i <= 1'b0;
      ext_irq_i   <= 1'b0;
      osc_irq_i   <= 1'b0;
      sys_reset_i <= 1'b0;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask

   // returns just after a counter step, leaving almost a full period
   task automatic sync;
      logic [7:0] x;
      logic [7:0] y;
      int         n;
      rd(ADDR_CTRL, x);
      y = x;
      n = 0;
      while (y === x && n < P) begin
         rd(ADDR_CTRL, y);
         n++;
      end
      if (n >= P) begin
         fails++;
         $display("[FAIL] counter step expected change seen none");
         test_done();
      end
   endtask

   // reset pulse must come within lo..hi cycles
   task automatic exp_rst(input int lo, input int hi);
      int n;
      n = 0;
      #1;
      while (wdg_reset_o !== 1'b1) begin
         @(posedge mclk_i);
         #1;
         n++;
         if (n > hi) begin
            fails++;
            $display("[FAIL] wdg_reset_o expected pulse seen none");
            test_done();
         end
      end
      cmp_count++;
      if (n < lo) begin
         fails++;
         $display("[FAIL] reset delay expected %0d..%0d seen %0d", lo, hi, n);
      end
   endtask

   // timeout bound in oscillator periods, divisions truncated
   function automatic logic [23:0] bnd(input int cv, input int ms, input int ls, input bit mx);
      int q;
      int b0;
      q  = (4 * cv) / ms;
      b0 = mx ? 16384 : (ls + 128) * 64;
      if ((mx && cv <= ms / 4) || (!mx && cv < ms / 4))
         return 24'(b0 + 16384 * cv);
      return 24'(b0 + 16384 * (cv - q) + (192 + ls) * 64 * q);
   endfunction

   // =====================================================================
   // main sequence
   initial begin
      rst_i       = 1'b1;
      addr_i      = '0;
      wdata_i     = '0;
      wr_i        = 1'b0;
      rd_i        = 1'b0;
      halt_exec_i = 1'b0;
      ext_irq_i   = 1'b0;
      osc_irq_i   = 1'b0;
      sys_reset_i = 1'b0;
      fails       = 0;
      cmp_count   = 0;
      repeat (8) @(posedge mclk_i);
      rst_i <= 1'b0;
      // reset values and an unmapped address
      rd(ADDR_CTRL, a);
      chk("ctrl reset", 24'h00007F, 24'(a));
      rd(ADDR_OPT, a);
      chk("opt reset", 24'(OPT_RST), 24'(a));
      rd(ADDR_CLKCFG, a);
      chk("clkcfg reset", 24'(CLK_RST), 24'(a));
      rd(8'h55, a);
      chk("unmapped", 24'(READ_NONE), 24'(a));
      // counter steps once per period while disabled
      rd(ADDR_CTRL, a);
      repeat (P - 2) @(posedge mclk_i);
      rd(ADDR_CTRL, b);
      chk("free count", 24'(a - 8'h01), 24'(b));
      // activation bit cannot be cleared by software
      wr(ADDR_CTRL, 8'hFF);
      wr(ADDR_CTRL, 8'h7F);
      rd(ADDR_CTRL, a);
      chk("act sticky", 24'h000080, 24'(a & 8'h80));
      sync;
      wr(ADDR_CTRL, 8'hC1);
      exp_rst(P, 2 * P + 4);
      rd(ADDR_CTRL, a);
      chk("ctrl after wdg reset", 24'h00007F, 24'(a));
      // bounds for every timebase at the branch edges
      for (t = 0; t < 4; t++) begin
         wr(ADDR_CLKCFG, 8'(t << CLK_TB_LO));
         cs = '{0, msb[t] / 4, msb[t] / 4 + 1, 63};
         for (k = 0; k < 4; k++) begin
            wr(ADDR_CTRL, 8'(8'h40 | cs[k]));
            i = 0;
            do begin
               rd(ADDR_CTRL, a);
               @(posedge mclk_i);
               for (c = 0; c < 6; c++)
                  rd(ADDR_BND + 8'(c), by[c]);
               rd(ADDR_CTRL, b);
               i++;
            end while (a !== b && i < 4);
            chk("tmin", bnd(int'(a[5:0]), msb[t], lsb[t], 1'b0), {by[2], by[1], by[0]});
            chk("tmax", bnd(int'(a[5:0]), msb[t], lsb[t], 1'b1), {by[5], by[4], by[3]});
         end
      end
      // halt with the halt-reset option resets at once
      wr(ADDR_CLKCFG, 8'h00);
      wr(ADDR_OPT, 8'(1 << OPT_HRST));
      pulse(0);
      exp_rst(0, 3);
      wr(ADDR_OPT, 8'h00);
      // active-halt freezes, timer and external wake resume at once
      wr(ADDR_CLKCFG, 8'(1 << CLK_TIE));
      wr(ADDR_CTRL, 8'hC8);
      for (k = 1; k < 3; k++) begin
         pulse(0);
         cyc(2);
         chk("act_halted_o", 24'h000001, 24'(act_halted_o));
         rd(ADDR_STAT, a);
         chk("status", 24'h000005, 24'(a));
         rd(ADDR_CTRL, a);
         repeat (3 * P) @(posedge mclk_i);
         rd(ADDR_CTRL, b);
         chk("frozen count", 24'(a), 24'(b));
         pulse(k);
         cyc(2);
         chk("act_halted_o", 24'h000000, 24'(act_halted_o));
         rd(ADDR_CTRL, a);
         repeat (P - 2) @(posedge mclk_i);
         rd(ADDR_CTRL, b);
         chk("resumed count", 24'(a - 8'h01), 24'(b));
      end
      // reset out of active-halt waits before counting
      pulse(0);
      pulse(3);
      cyc(200);
      rd(ADDR_CTRL, a);
      chk("count held", 24'h00007F, 24'(a));
      cyc(P + 60);
      rd(ADDR_CTRL, a);
      chk("count moving", 24'h000001, 24'(a < 8'h7F));
      // plain halt: one step, frozen, wake after short and long delay
      wr(ADDR_CLKCFG, 8'h00);
      for (k = 0; k < 2; k++) begin
         wr(ADDR_OPT, 8'(k << OPT_LWAKE));
         sync;
         wr(ADDR_CTRL, 8'hC1);
         pulse(0);
         repeat (3 * P) @(posedge mclk_i);
         rd(ADDR_CTRL, a);
         chk("halt count", 24'h0000C0, 24'(a));
         chk("halted_o", 24'h000001, 24'(halted_o));
         pulse(1);
         i = k ? int'(WAKE_LONG) : int'(WAKE_SHORT);
         exp_rst(i, i + P + 4);
      end
      // reset ends plain halt with the watchdog disabled
      wr(ADDR_OPT, 8'h00);
      wr(ADDR_CTRL, 8'hC8);
      pulse(0);
      cyc(3);
      pulse(3);
      cyc(2);
      chk("halted_o", 24'h000000, 24'(halted_o));
      rd(ADDR_CTRL, a);
      chk("act after reset", 24'h000000, 24'(a & 8'h80));
      // hardware option resets with the activation bit clear
      wr(ADDR_OPT, 8'(1 << OPT_HW));
      sync;
      wr(ADDR_CTRL, 8'h41);
      exp_rst(P, 2 * P + 4);
      test_done();
   end
endmodule
